// *** src/rie_top.sv ***
// interrupt status, page select, revision and count masks of a repeater,
// with the per-port event counters that the masks steer.
// assumes: event pulses one cycle wide and synchronous to ref_clk.
`timescale 1ns/1ns
`include "rie_regs.svh"

module rie_top #(
    // arbitrary value, stands for the silicon revision code
    parameter logic [7:0] REV_CODE = 8'h5a
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // register bus
    input wire rie_pkg::rie_axi_req_t axiReq,
    output rie_pkg::rie_axi_rsp_t axiRsp,
    // repeater activity
    input wire logic pktStart,
    input wire rie_pkg::rie_rt_t rtEvt,
    input wire rie_pkg::rie_evt_t [12:0] portEvt,
    input wire logic [12:0] flagLatch,
    // interrupt
    output logic rtIrq
);

    // ==================================================
    // state
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic [2:0] page_q;
    logic [7:0] lowMask_q, upMask_q;
    logic partDis_q;
    logic rxPend_q, colPend_q;
    logic [3:0] rxPort_q, colPort_q, rrPtr_q;
    logic [12:0] partPend_q;
    logic [12:0][15:0] cnt_q;
    logic flagFound_q, lowSeen_q, highSeen_q, fullSeen_q;
    logic rtIrq_q;

    // ==================================================
    // functions
    function automatic logic [4:0] rr_pick(input logic [12:0] vec, input logic [3:0] ptr);
        logic [4:0] res;
        logic [4:0] idx;
        res = 5'h00;
        idx = 5'h00;
        for (int k = 12; k >= 0; k--) begin
            idx = 5'(ptr) + 5'(k);
            if (idx > 5'h0c) begin
                idx = idx - 5'h0d;
            end
            if (vec[idx[3:0]]) begin
                res = {1'b1, idx[3:0]};
            end
        end
        return res;
    endfunction

    function automatic logic [3:0] cnt_amt(input rie_pkg::rie_evt_t e, input logic [7:0] lm,
                                           input logic [7:0] um);
        logic [3:0] n;
        n = 4'h0;
        for (int b = 0; b < 8; b++) begin
            n = n + {3'h0, e.lower[b] & lm[b]};
        end
        n = n + {3'h0, e.txCol & um[`RIE_UM_TXCOL]};
        n = n + {3'h0, e.rxCol & um[`RIE_UM_RXCOL]};
        // an owc also pulses its collision type, so both enables give two counts
        n = n + {3'h0, e.owcCol & um[`RIE_UM_OWC]};
        return n;
    endfunction

    // ==================================================
    // bus decode
    wire [5:0] rdIdx = axiReq.araddr[7:2];
    wire [5:0] wrIdx = axiReq.awaddr[7:2];
    wire pageZero = page_q == 3'h0;
    wire arHs = axiReq.arvalid && arready_q;
    wire wrHs = axiReq.awvalid && axiReq.wvalid && awready_q && wready_q;
    wire wrByte = wrHs && axiReq.wstrb[0];
    wire [7:0] wrData = axiReq.wdata[7:0];
    wire rdCnt = rdIdx[5:4] == `RIE_IDX_CNT_HI && rdIdx[3:0] <= `RIE_LAST_PORT;
    wire [3:0] cntSel = rdIdx[3:0];
    wire rdPg0 = pageZero && (rdIdx == `RIE_IDX_REV || rdIdx == `RIE_IDX_LMASK
                              || rdIdx == `RIE_IDX_UMASK);
    wire rdHit = rdIdx == `RIE_IDX_IRQ_STAT || rdIdx == `RIE_IDX_PAGE || rdPg0 || rdCnt
                 || rdIdx == `RIE_IDX_CFG;
    wire wrPg0 = pageZero && (wrIdx == `RIE_IDX_REV || wrIdx == `RIE_IDX_LMASK
                              || wrIdx == `RIE_IDX_UMASK);
    wire wrHit = wrIdx == `RIE_IDX_IRQ_STAT || wrIdx == `RIE_IDX_PAGE || wrPg0
                 || (wrIdx[5:4] == `RIE_IDX_CNT_HI && wrIdx[3:0] <= `RIE_LAST_PORT)
                 || wrIdx == `RIE_IDX_CFG;
    wire wrPage = wrByte && wrIdx == `RIE_IDX_PAGE;
    wire wrLow = wrByte && pageZero && wrIdx == `RIE_IDX_LMASK;
    wire wrUp = wrByte && pageZero && wrIdx == `RIE_IDX_UMASK;
    wire wrCfg = wrByte && wrIdx == `RIE_IDX_CFG;

    // ==================================================
    // interrupt status view
    wire [4:0] partPick = rr_pick(partPend_q, rrPtr_q);
    wire partFound = partPick[4];
    wire [3:0] partSel = partPick[3:0];
    wire [7:0] irqStatView = rxPend_q ? {rxPort_q, `RIE_SRC_RX} :
                             colPend_q ? {colPort_q, `RIE_SRC_COL} :
                             partFound ? {partSel, `RIE_SRC_PART} :
                             `RIE_NO_IRQ;
    wire irqStatRead = arHs && rdIdx == `RIE_IDX_IRQ_STAT;
    wire clrRx = irqStatRead && rxPend_q;
    wire clrCol = irqStatRead && !rxPend_q && colPend_q;
    wire clrPart = irqStatRead && !rxPend_q && !colPend_q && partFound;
    wire [12:0] partOne = 13'h0001 << partSel;
    // a packet start drops every partition report at once, unread or not
    wire [12:0] partKeep = pktStart ? 13'h0000 : clrPart ? ~partOne : 13'h1fff;
    wire [3:0] rrNext = partSel == `RIE_LAST_PORT ? 4'h0 : partSel + 4'h1;

    // ==================================================
    // counters
    logic [12:0][15:0] cnt_d;
    logic [12:0] anyLow, anyHigh, anyFull;
    genvar gp;
    generate
        for (gp = 0; gp < `RIE_NPORTS; gp++) begin : g_cnt
            wire [3:0] amt = cnt_amt(portEvt[gp], lowMask_q, upMask_q);
            wire clrRd = arHs && rdCnt && cntSel == 4'(gp)
                         && upMask_q[`RIE_UM_CLR_ON_READ];
            wire [15:0] base = clrRd ? 16'h0000 : cnt_q[gp];
            wire [16:0] sum = {1'b0, base} + {13'h0000, amt};
            wire frz = upMask_q[`RIE_UM_FREEZE] && sum[16];
            // an event in the cleared cycle still counts from zero
            assign cnt_d[gp] = frz ? `RIE_CNT_FULL : sum[15:0];
            assign anyLow[gp] = cnt_q[gp] < `RIE_CNT_LOW;
            assign anyHigh[gp] = cnt_q[gp] > `RIE_CNT_HIGH;
            assign anyFull[gp] = cnt_q[gp] == `RIE_CNT_FULL;
        end
    endgenerate

    // ==================================================
    // read data
    wire [7:0] pageView = {fullSeen_q, highSeen_q, lowSeen_q, flagFound_q, 1'b0, page_q};
    wire [31:0] rdMux = rdIdx == `RIE_IDX_IRQ_STAT ? {24'h0, irqStatView} :
                        rdIdx == `RIE_IDX_PAGE ? {24'h0, pageView} :
                        rdCnt ? {16'h0, cnt_q[cntSel]} :
                        rdIdx == `RIE_IDX_CFG ? {31'h0, partDis_q} :
                        !pageZero ? 32'h0 :
                        rdIdx == `RIE_IDX_REV ? {24'h0, REV_CODE} :
                        rdIdx == `RIE_IDX_LMASK ? {24'h0, lowMask_q} :
                        rdIdx == `RIE_IDX_UMASK ? {24'h0, upMask_q} : 32'h0;

    // ==================================================
    // bus handshake
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `RIE_RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= `RIE_RESP_OKAY;
            rdata_q <= 32'h0;
        end else begin
            // ready pulses one cycle, so a held valid is never taken twice
            awready_q <= axiReq.awvalid && axiReq.wvalid && !awready_q && !bvalid_q;
            wready_q <= axiReq.awvalid && axiReq.wvalid && !wready_q && !bvalid_q;
            if (wrHs) begin
                bvalid_q <= 1'b1;
                bresp_q <= wrHit ? `RIE_RESP_OKAY : `RIE_RESP_DECERR;
            end else if (axiReq.bready) begin
                bvalid_q <= 1'b0;
            end
            arready_q <= axiReq.arvalid && !arready_q && !rvalid_q;
            if (arHs) begin
                rvalid_q <= 1'b1;
                rdata_q <= rdHit ? rdMux : 32'h0;
                rresp_q <= rdHit ? `RIE_RESP_OKAY : `RIE_RESP_DECERR;
            end else if (axiReq.rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // ==================================================
    // software registers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            page_q <= `RIE_PAGE_RST;
            lowMask_q <= `RIE_MASK_RST;
            upMask_q <= `RIE_MASK_RST;
            partDis_q <= `RIE_CFG_RST;
        end else begin
            if (wrPage) begin
                page_q <= wrData[2:0];
            end
            if (wrLow) begin
                lowMask_q <= wrData;
            end
            if (wrUp) begin
                // reserved bits are held at zero whatever software writes
                upMask_q <= wrData & `RIE_UM_WRITABLE;
            end
            if (wrCfg) begin
                partDis_q <= wrData[`RIE_CFG_PART_DIS];
            end
        end
    end

    // ==================================================
    // real-time interrupt sources, set wins over clear
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rxPend_q <= 1'b0;
            rxPort_q <= 4'h0;
            colPend_q <= 1'b0;
            colPort_q <= 4'h0;
            partPend_q <= 13'h0000;
            rrPtr_q <= 4'h0;
            rtIrq_q <= 1'b0;
        end else begin
            if (rtEvt.rxValid) begin
                rxPend_q <= 1'b1;
                rxPort_q <= rtEvt.rxPort;
            end else if (pktStart || clrRx) begin
                rxPend_q <= 1'b0;
            end
            if (rtEvt.colValid) begin
                colPend_q <= 1'b1;
                colPort_q <= rtEvt.colPort;
            end else if (pktStart || clrCol) begin
                colPend_q <= 1'b0;
            end
            partPend_q <= (partPend_q & partKeep) | rtEvt.partVec;
            if (clrPart) begin
                rrPtr_q <= rrNext;
            end
            rtIrq_q <= |partPend_q && !partDis_q;
        end
    end

    // ==================================================
    // counters and summary flags
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cnt_q <= '0;
            flagFound_q <= 1'b0;
            lowSeen_q <= 1'b0;
            highSeen_q <= 1'b0;
            fullSeen_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            flagFound_q <= |flagLatch;
            lowSeen_q <= |anyLow;
            highSeen_q <= |anyHigh;
            fullSeen_q <= |anyFull;
        end
    end

    // ==================================================
    // outputs
    assign axiRsp.awready = awready_q;
    assign axiRsp.wready = wready_q;
    assign axiRsp.bvalid = bvalid_q;
    assign axiRsp.bresp = bresp_q;
    assign axiRsp.arready = arready_q;
    assign axiRsp.rvalid = rvalid_q;
    assign axiRsp.rdata = rdata_q;
    assign axiRsp.rresp = rresp_q;
    assign rtIrq = rtIrq_q;

    // ==================================================
    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    a_pkt_discard: assert property (
        pktStart && !rtEvt.rxValid && !rtEvt.colValid && rtEvt.partVec == 13'h0000
        |=> irqStatView == `RIE_NO_IRQ)
        else $error("pending interrupt survived packet start");
    a_rx_first: assert property (
        rxPend_q |-> irqStatView == {rxPort_q, `RIE_SRC_RX})
        else $error("receive source not shown first");
    a_col_second: assert property (
        !rxPend_q && colPend_q |-> irqStatView == {colPort_q, `RIE_SRC_COL})
        else $error("collision source not shown second");
    a_part_shown: assert property (
        !rxPend_q && !colPend_q && partPend_q != 13'h0000
        |-> irqStatView[3:0] == `RIE_SRC_PART && partPend_q[irqStatView[7:4]])
        else $error("shown partition port not pending");
    a_read_clears: assert property (
        clrRx && !rtEvt.rxValid |=> !rxPend_q)
        else $error("read did not clear receive source");
    a_col_clears: assert property (
        clrCol && !rtEvt.colValid |=> !colPend_q)
        else $error("read did not clear collision source");
    a_part_round: assert property (
        clrPart && rtEvt.partVec == 13'h0000 |=> !partPend_q[$past(partSel)])
        else $error("reported partition port not retired");
    a_idle_ones: assert property (
        !rxPend_q && !colPend_q && partPend_q == 13'h0000 |-> irqStatView == 8'hff)
        else $error("idle status not all ones");
    a_page_write: assert property (
        wrPage |=> page_q == $past(wrData[2:0]) ##1 pageView[2:0] == $past(page_q))
        else $error("page select not switched");
    a_rev_fixed: assert property (
        arHs && pageZero && rdIdx == `RIE_IDX_REV |=> rdata_q[7:0] == REV_CODE)
        else $error("revision code changed");
    a_flag_found: assert property (
        flagLatch != 13'h0000 |=> flagFound_q)
        else $error("flag found not reported");
    a_flag_idle: assert property (
        flagLatch == 13'h0000 |=> !flagFound_q)
        else $error("flag found without latch");
    a_low_seen: assert property (
        cnt_q[0] < `RIE_CNT_LOW |=> lowSeen_q)
        else $error("low counter not reported");
    a_high_seen: assert property (
        cnt_q[0] > `RIE_CNT_HIGH |=> highSeen_q)
        else $error("high counter not reported");
    a_mask_off: assert property (
        lowMask_q == 8'h00 && upMask_q[5:3] == 3'h0 |-> g_cnt[0].amt == 4'h0)
        else $error("disabled event counted");
    a_owc_twice: assert property (
        portEvt[0] == 11'h500 && upMask_q[`RIE_UM_TXCOL] && upMask_q[`RIE_UM_OWC]
        |-> g_cnt[0].amt == 4'h2)
        else $error("out of window collision not counted twice");
    a_clear_read: assert property (
        arHs && rdCnt && cntSel == 4'h0 && upMask_q[`RIE_UM_CLR_ON_READ]
        && g_cnt[0].amt == 4'h0 |=> cnt_q[0] == 16'h0000)
        else $error("counter not cleared by read");
    a_read_keeps: assert property (
        arHs && rdCnt && cntSel == 4'h0 && !upMask_q[`RIE_UM_CLR_ON_READ]
        && g_cnt[0].amt == 4'h0 |=> $stable(cnt_q[0]))
        else $error("counter changed by plain read");
    a_full_seen: assert property (
        cnt_q[0] == `RIE_CNT_FULL |=> fullSeen_q)
        else $error("full counter not reported");
    a_freeze_hold: assert property (
        upMask_q[`RIE_UM_FREEZE] && cnt_q[0] == `RIE_CNT_FULL
        && !(arHs && rdCnt && cntSel == 4'h0) |=> cnt_q[0] == `RIE_CNT_FULL)
        else $error("frozen counter moved");
    a_wrap_zero: assert property (
        !upMask_q[`RIE_UM_FREEZE] && cnt_q[0] == `RIE_CNT_FULL && g_cnt[0].amt == 4'h1
        && !(arHs && rdCnt && cntSel == 4'h0) |=> cnt_q[0] == 16'h0000)
        else $error("counter did not wrap");
    a_part_irq: assert property (
        partPend_q != 13'h0000 && !partDis_q |=> rtIrq)
        else $error("partition interrupt missing");
    a_irq_off: assert property (
        partDis_q |=> !rtIrq)
        else $error("partition interrupt while disabled");

endmodule

// *** src/rie_regs.svh ***
// register indices, field positions, reset values and thresholds of the
// repeater interrupt and event-mask group.
// assumes: byte address on the bus is four times the index.
`ifndef RIE_REGS_SVH
`define RIE_REGS_SVH

// ==================================================
// register indices
`define RIE_IDX_IRQ_STAT 6'h0f
`define RIE_IDX_PAGE 6'h10
`define RIE_IDX_REV 6'h11
`define RIE_IDX_LMASK 6'h12
`define RIE_IDX_UMASK 6'h13
`define RIE_IDX_CNT_HI 2'b10
`define RIE_IDX_CFG 6'h30

// ==================================================
// fields
`define RIE_SRC_COL 4'hd
`define RIE_SRC_RX 4'hb
`define RIE_SRC_PART 4'h7
`define RIE_NO_IRQ 8'hff
`define RIE_UM_CLR_ON_READ 0
`define RIE_UM_FREEZE 1
`define RIE_UM_TXCOL 3
`define RIE_UM_RXCOL 4
`define RIE_UM_OWC 5
`define RIE_UM_WRITABLE 8'h3b
`define RIE_CFG_PART_DIS 0

// ==================================================
// reset values and thresholds
`define RIE_PAGE_RST 3'h0
`define RIE_MASK_RST 8'h00
`define RIE_CFG_RST 1'b1
`define RIE_CNT_LOW 16'h00ff
`define RIE_CNT_HIGH 16'hc000
`define RIE_CNT_FULL 16'hffff
`define RIE_NPORTS 13
`define RIE_LAST_PORT 4'hc
`define RIE_RESP_OKAY 2'b00
`define RIE_RESP_DECERR 2'b11

`endif

// *** src/rie_pkg.sv ***
// types shared by the interrupt and event-mask block and its bench.
// assumes: 13 ports, AXI4-Lite with 8-bit address and 32-bit data.
package rie_pkg;

    // ==================================================
    // bus carriers
    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } rie_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } rie_axi_rsp_t;

    // ==================================================
    // repeater-side events
    typedef struct packed {
        logic rxValid;
        logic [3:0] rxPort;
        logic colValid;
        logic [3:0] colPort;
        logic [12:0] partVec;
    } rie_rt_t;

    // bit order matches the count masks: lower 0..7, then txcol, rxcol, owc
    typedef struct packed {
        logic owcCol;
        logic rxCol;
        logic txCol;
        logic [7:0] lower;
    } rie_evt_t;

endpackage

// *** tb/rie_cpu_model.sv ***
// processor-side model: AXI4-Lite master, one write or one read at a time.
// assumes: the slave takes the address within 64 cycles and responds within 128 in all, else timeouts counts it.
`timescale 1ns/1ns
module rie_cpu_model (
    // clock
    input wire logic ref_clk,
    // register bus
    output rie_pkg::rie_axi_req_t axiReq,
    input wire rie_pkg::rie_axi_rsp_t axiRsp
);
    int timeouts = 0;

    // response ready held high throughout, so no toggling races between accesses
    initial begin
        axiReq = '0;
        axiReq.bready = 1'b1;
        axiReq.rready = 1'b1;
    end

    // ==================================================
    // write: address and data offered together, each held until its own ready
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        int n;
        logic awDone;
        logic wDone;
        n = 0;
        awDone = 1'b0;
        wDone = 1'b0;
        axiReq.awaddr <= a;
        axiReq.wdata <= d;
        axiReq.wstrb <= 4'hf;
        axiReq.awvalid <= 1'b1;
        axiReq.wvalid <= 1'b1;
        while (!(awDone && wDone) && n < 64) begin
            @(posedge ref_clk);
            n++;
            if (!awDone && axiRsp.awready === 1'b1) begin
                awDone = 1'b1;
                axiReq.awvalid <= 1'b0;
            end
            if (!wDone && axiRsp.wready === 1'b1) begin
                wDone = 1'b1;
                axiReq.wvalid <= 1'b0;
            end
        end
        do begin
            @(posedge ref_clk);
            n++;
        end while (axiRsp.bvalid !== 1'b1 && n < 128);
        resp = axiRsp.bresp;
        if (axiRsp.bvalid !== 1'b1) begin
            timeouts++;
        end
    endtask

    // ==================================================
    // read: address held until taken, data taken at the edge rvalid is seen
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        int n;
        n = 0;
        axiReq.araddr <= a;
        axiReq.arvalid <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (axiRsp.arready !== 1'b1 && n < 64);
        axiReq.arvalid <= 1'b0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (axiRsp.rvalid !== 1'b1 && n < 128);
        d = axiRsp.rdata;
        resp = axiRsp.rresp;
        if (axiRsp.rvalid !== 1'b1) begin
            timeouts++;
        end
    endtask
endmodule

// *** tb/repeater_interrupt_event_mask_tb.sv ***
// self-checking bench for the repeater interrupt and event-mask block.
// assumes: the processor model drives the register bus; bench drives repeater events.
`timescale 1ns/1ns
module repeater_interrupt_event_mask_tb;
    logic ref_clk;
    logic srst;
    rie_pkg::rie_axi_req_t axiReq;
    rie_pkg::rie_axi_rsp_t axiRsp;
    logic pktStart;
    rie_pkg::rie_rt_t rtEvt;
    rie_pkg::rie_evt_t [12:0] portEvt;
    logic [12:0] flagLatch;
    logic rtIrq;
    int err_count = 0;
    int n_compared = 0;
    // arbitrary revision code
    localparam logic [7:0] REV = 8'h3c;
    localparam logic [1:0] OK = 2'b00;
    localparam logic [1:0] DEC = 2'b11;

    rie_top #(.REV_CODE(REV)) dut (.ref_clk(ref_clk), .srst(srst), .axiReq(axiReq),
        .axiRsp(axiRsp), .pktStart(pktStart), .rtEvt(rtEvt), .portEvt(portEvt),
        .flagLatch(flagLatch), .rtIrq(rtIrq));
    rie_cpu_model cpu (.ref_clk(ref_clk), .axiReq(axiReq), .axiRsp(axiRsp));

    // ==================================================
    // checking and closing
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic bus_ok();
        if (cpu.timeouts != 0) begin
            err_count++;
            finish_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        cpu.wr(a, d, r);
        bus_ok();
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        cpu.rd(a, d, r);
        bus_ok();
        chk("rresp", {30'h0, er}, {30'h0, r});
        chk("rdata", e, d);
    endtask
    // hold one port's event pulses for n cycles, so they count n times
    task automatic evt(input int p, input rie_pkg::rie_evt_t e, input int n);
        repeat (n) begin
            @(posedge ref_clk);
            portEvt[p] <= e;
        end
        @(posedge ref_clk);
        portEvt[p] <= '0;
    endtask
    task automatic rt(input rie_pkg::rie_rt_t v, input logic pkt);
        @(posedge ref_clk);
        rtEvt <= v;
        pktStart <= pkt;
        @(posedge ref_clk);
        rtEvt <= '0;
        pktStart <= 1'b0;
    endtask

    // ==================================================
    // scenarios
    task automatic t_reset();
        rd(8'h40, 32'h20, OK);
        rd(8'h44, {24'h0, REV}, OK);
        wr(8'h44, 32'h00, OK);
        rd(8'h44, {24'h0, REV}, OK);
        rd(8'h3c, 32'hff, OK);
        rd(8'h50, 32'h0, DEC);
        wr(8'h50, 32'h1, DEC);
    endtask
    task automatic t_masks();
        wr(8'h48, 32'ha5, OK);
        rd(8'h48, 32'ha5, OK);
        // reserved bits 2, 6 and 7 written as zero, as software must
        wr(8'h4c, 32'h3b, OK);
        rd(8'h4c, 32'h3b, OK);
        wr(8'h4c, 32'h00, OK);
    endtask
    task automatic t_page();
        wr(8'h40, 32'h03, OK);
        rd(8'h40, 32'h23, OK);
        rd(8'h44, 32'h0, DEC);
        wr(8'h40, 32'h00, OK);
        flagLatch <= 13'h0040;
        rd(8'h40, 32'h30, OK);
        flagLatch <= 13'h0;
    endtask
    task automatic t_prio();
        rt({1'b1, 4'h5, 1'b1, 4'h9, 13'h0084}, 1'b0);
        rd(8'h3c, 32'h5b, OK);
        rd(8'h3c, 32'h9d, OK);
        rd(8'h3c, 32'h27, OK);
        rd(8'h3c, 32'h77, OK);
        rd(8'h3c, 32'hff, OK);
        rt({1'b0, 4'h0, 1'b0, 4'h0, 13'h0102}, 1'b0);
        rd(8'h3c, 32'h87, OK);
        rd(8'h3c, 32'h17, OK);
    endtask
    task automatic t_pkt();
        rt({1'b1, 4'h3, 1'b1, 4'h6, 13'h0010}, 1'b0);
        rt('0, 1'b1);
        rd(8'h3c, 32'hff, OK);
    endtask
    task automatic t_irq();
        wr(8'hc0, 32'h0, OK);
        rt({1'b0, 4'h0, 1'b0, 4'h0, 13'h0010}, 1'b0);
        repeat (2) @(posedge ref_clk);
        chk("rtIrq", 32'h1, {31'h0, rtIrq});
        rd(8'h3c, 32'h47, OK);
        repeat (2) @(posedge ref_clk);
        chk("rtIrq", 32'h0, {31'h0, rtIrq});
        wr(8'hc0, 32'h1, OK);
        rt({1'b0, 4'h0, 1'b0, 4'h0, 13'h0010}, 1'b0);
        repeat (2) @(posedge ref_clk);
        chk("rtIrq", 32'h0, {31'h0, rtIrq});
        rd(8'h3c, 32'h47, OK);
    endtask
    task automatic t_count();
        wr(8'h48, 32'hff, OK);
        wr(8'h4c, 32'h38, OK);
        for (int i = 0; i < 8; i++) begin
            evt(0, 11'h001 << i, 1);
        end
        evt(0, 11'h500, 1);
        rd(8'h80, 32'd10, OK);
        wr(8'h48, 32'h00, OK);
        wr(8'h4c, 32'h00, OK);
        evt(0, 11'h7ff, 3);
        rd(8'h80, 32'd10, OK);
        wr(8'h4c, 32'h20, OK);
        evt(0, 11'h500, 1);
        evt(0, 11'h300, 1);
        rd(8'h80, 32'd11, OK);
        wr(8'h4c, 32'h01, OK);
        rd(8'h80, 32'd11, OK);
        rd(8'h80, 32'd0, OK);
    endtask
    task automatic t_full();
        wr(8'h48, 32'hff, OK);
        wr(8'h4c, 32'h38, OK);
        // eleven enabled pulses a cycle keeps the climb to the top short
        evt(0, 11'h7ff, 5957);
        rd(8'h80, 32'hfff7, OK);
        rd(8'h40, 32'h60, OK);
        evt(0, 11'h0ff, 1);
        rd(8'h40, 32'he0, OK);
        wr(8'h4c, 32'h3a, OK);
        evt(0, 11'h001, 1);
        rd(8'h80, 32'hffff, OK);
        wr(8'h4c, 32'h38, OK);
        evt(0, 11'h001, 1);
        rd(8'h80, 32'h0, OK);
        rd(8'h40, 32'h20, OK);
    endtask

    // ==================================================
    // clock, reset and sequence
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        srst = 1'b1;
        pktStart = 1'b0;
        rtEvt = '0;
        portEvt = '0;
        flagLatch = '0;
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        t_reset();
        t_masks();
        t_page();
        t_prio();
        t_pkt();
        t_irq();
        t_count();
        t_full();
        finish_test();
    end
endmodule
